// file: shared/rpr_pkg.sv
// Package for the radio packet receive configuration block: register map, fields, resets and states.
// Behaviour
// - Per debug pin, a polarity bit: clear drives signal active high, set drives it inverted.
// - Per debug pin, a six-bit selector picks the internal signal routed out; resets to zero.
// - Sync word is 16 bits from high and low byte registers, reset 0xD3 and 0x91.
// - Fixed-length mode uses the packet length register as exact length; register resets 0xFF.
// - Variable-length mode treats the packet length register as the largest accepted length.
// - Preamble quality counter rises by one for each bit differing from the previous bit.
// - Preamble quality counter falls by eight for each bit equal to the previous bit.
// - Sync detection is allowed only while the counter reaches four times the threshold setting.
// - A threshold setting of zero accepts any detected sync word regardless of the counter.
// - With status append enabled, the default, two bytes carry RSSI, LQI and CRC-good.
// - Mode 01 accepts only packets whose address equals the own address.
// - Mode 10 accepts own address or broadcast address 0x00.
// - Mode 11 accepts own address or broadcast addresses 0x00 and 0xFF.
// - Received addresses are compared with an eight-bit own-address register, reset 0x00.
// - Two-bit length field: 00 selects fixed length, 01 selects variable length.
// - In variable-length mode the first byte after the sync word gives the length.
package rpr_pkg;

	// ==========================================================
	// Bus geometry.
	localparam int ADR_W = 18;
	localparam int DAT_W = 32;

	// ==========================================================
	// Register indices; the byte address on the bus is four times the index.
	localparam logic [15:0] IDX_SYNC_HIGH = 16'hDF00;
	localparam logic [15:0] IDX_SYNC_LOW = 16'hDF01;
	localparam logic [15:0] IDX_PKT_LEN = 16'hDF02;
	localparam logic [15:0] IDX_PKT_CTRL1 = 16'hDF03;
	localparam logic [15:0] IDX_PKT_CTRL0 = 16'hDF04;
	localparam logic [15:0] IDX_DEV_ADDR = 16'hDF05;
	localparam logic [15:0] IDX_PIN1_CFG = 16'hDF30;
	localparam logic [15:0] IDX_PIN0_CFG = 16'hDF31;
	localparam logic [15:0] IDX_RX_STATUS = 16'hDF3A;
	localparam logic [15:0] IDX_RX_COUNT = 16'hDF3B;

	// ==========================================================
	// Values after reset.
	localparam logic [7:0] SYNC_HIGH_RST = 8'hD3;
	localparam logic [7:0] SYNC_LOW_RST = 8'h91;
	localparam logic [7:0] PKT_LEN_RST = 8'hFF;
	localparam logic [7:0] PKT_CTRL1_RST = 8'h04;
	localparam logic [1:0] LEN_CFG_RST = 2'h1;
	localparam logic [7:0] DEV_ADDR_RST = 8'h00;
	localparam logic [7:0] PIN_CFG_RST = 8'h00;

	// ==========================================================
	// Field positions.
	localparam int PQT_LSB = 5;
	localparam int APPEND_BIT = 2;
	localparam int ADR_CHK_LSB = 0;
	localparam int PIN_INV_BIT = 6;
	localparam int PIN_DS_BIT = 7;
	localparam int PIN_SEL_W = 6;

	// ==========================================================
	// Field encodings.
	localparam logic [1:0] LEN_FIXED = 2'h0;
	localparam logic [1:0] ADR_NONE = 2'h0;
	localparam logic [1:0] ADR_OWN = 2'h1;
	localparam logic [1:0] ADR_BC0 = 2'h2;
	localparam logic [7:0] BCAST_LOW = 8'h00;
	localparam logic [7:0] BCAST_HIGH = 8'hFF;

	// ==========================================================
	// Debug signal numbers on the selector.
	localparam int DBG_PQ_GATE = 0;
	localparam int DBG_IN_PKT = 1;
	localparam int DBG_BYTE_VALID = 2;
	localparam int DBG_RX_BIT = 3;
	localparam int DBG_ADR_DROP = 4;

	// ==========================================================
	// Receive sequencer states.
	typedef enum logic [2:0] {
		ST_SEARCH,
		ST_LENGTH,
		ST_ADDRESS,
		ST_ADR_EMIT,
		ST_PAYLOAD,
		ST_STATUS1,
		ST_STATUS2
	} rpr_state_t;

endpackage

// file: core/rpr_preamble_qual.sv
// Preamble quality estimator that gates sync word detection.
module rpr_preamble_qual
	import rpr_pkg::*;
#(
	parameter int CNT_W = 5
) (
	// Clock and reset.
	input wire logic clk_in,
	input wire logic rst_n_in,
	// Received bit stream.
	input wire logic bit_in,
	input wire logic bit_valid_in,
	// Threshold setting and result.
	input wire logic [2:0] threshold_in,
	output logic gate_out
);

	typedef struct packed {
		logic prev;
		logic have_prev;
		logic [CNT_W-1:0] cnt;
	} rpr_pq_t;

	rpr_pq_t q_r;
	rpr_pq_t q_nxt;

	localparam logic [CNT_W-1:0] CNT_MAX = '1;
	localparam logic [CNT_W-1:0] CNT_DEC = CNT_W'(8);

	// ==========================================================
	// Counter update on each received bit; it saturates at both ends so noise cannot wrap it.
	always_comb begin
		q_nxt = q_r;
		if (bit_valid_in) begin
			q_nxt.prev = bit_in;
			q_nxt.have_prev = 1'b1;
			if (q_r.have_prev && (bit_in != q_r.prev)) begin
				if (q_r.cnt != CNT_MAX) begin
					q_nxt.cnt = q_r.cnt + CNT_W'(1);
				end
			end else if (q_r.have_prev) begin
				q_nxt.cnt = (q_r.cnt < CNT_DEC) ? '0 : q_r.cnt - CNT_DEC;
			end
		end
	end

	always_ff @(posedge clk_in) begin
		if (!rst_n_in) begin
			q_r <= '0;
		end else begin
			q_r <= q_nxt;
		end
	end

	// A zero setting opens the gate; otherwise the counter must reach four times the setting.
	assign gate_out = (threshold_in == 3'h0) ||
		({2'b00, q_r.cnt} >= {{(CNT_W-3){1'b0}}, threshold_in, 2'b00});

endmodule

// file: core/rpr_packet_rx.sv
// Radio packet receive handler: sync search, length and address filtering, status append, debug pins.
//
// The implementer's own choice: the Wishbone register port.
module rpr_packet_rx
	import rpr_pkg::*;
#(
	parameter int PQ_CNT_W = 5
) (
	// Clock and reset.
	input wire logic CORE_CLK_IN,
	input wire logic RST_N_IN,
	// Wishbone slave.
	input wire logic WB_CYC_IN,
	input wire logic WB_STB_IN,
	input wire logic WB_WE_IN,
	input wire logic [ADR_W-1:0] WB_ADR_IN,
	input wire logic [3:0] WB_SEL_IN,
	input wire logic [DAT_W-1:0] WB_DAT_IN,
	output logic [DAT_W-1:0] WB_DAT_OUT,
	output logic WB_ACK_OUT,
	// Demodulated bit stream and per-packet link quality.
	input wire logic RX_BIT_IN,
	input wire logic RX_BIT_VALID_IN,
	input wire logic [7:0] RSSI_IN,
	input wire logic [6:0] LQI_IN,
	input wire logic CRC_OK_IN,
	// Received bytes.
	output logic [7:0] RX_DATA_OUT,
	output logic RX_VALID_OUT,
	output logic RX_LAST_OUT,
	// Debug pins and drive strength control.
	output logic [1:0] DBG_PIN_OUT,
	output logic DBG_DRIVE_STRENGTH_OUT
);

	typedef struct packed {
		logic [7:0] sync_high;
		logic [7:0] sync_low;
		logic [7:0] pkt_len;
		logic [7:0] ctrl1;
		logic [1:0] len_cfg;
		logic [7:0] dev_addr;
		logic [7:0] pin1_cfg;
		logic [7:0] pin0_cfg;
		logic ack;
		logic [7:0] rdat;
		rpr_state_t st;
		logic [15:0] shift;
		logic [2:0] bitcnt;
		logic [7:0] remain;
		logic [7:0] hold;
		logic [7:0] dout;
		logic dvalid;
		logic dlast;
		logic drop;
		logic [7:0] rx_count;
		logic [1:0] dbg;
	} rpr_core_t;

	rpr_core_t r;
	rpr_core_t n;

	logic pq_gate;
	logic [2:0] pq_threshold;
	logic [1:0] adr_mode;
	logic append_en;
	logic req;
	logic [15:0] idx;
	logic [15:0] sh_next;
	logic byte_done;
	logic [7:0] rx_byte;
	logic [63:0] dbg_sig;
	logic [1:0] dbg_nxt;

	assign pq_threshold = r.ctrl1[PQT_LSB +: 3];
	assign adr_mode = r.ctrl1[ADR_CHK_LSB +: 2];
	assign append_en = r.ctrl1[APPEND_BIT];
	assign req = WB_CYC_IN && WB_STB_IN && !r.ack;
	assign idx = WB_ADR_IN[ADR_W-1:2];
	assign sh_next = {r.shift[14:0], RX_BIT_IN};
	assign byte_done = RX_BIT_VALID_IN && (r.bitcnt == 3'h7);
	assign rx_byte = sh_next[7:0];

	// ==========================================================
	// Preamble quality estimator.
	rpr_preamble_qual #(
		.CNT_W(PQ_CNT_W)
	) u_pq (
		.clk_in(CORE_CLK_IN),
		.rst_n_in(RST_N_IN),
		.bit_in(RX_BIT_IN),
		.bit_valid_in(RX_BIT_VALID_IN),
		.threshold_in(pq_threshold),
		.gate_out(pq_gate)
	);

	// Address filter over the four modes.
	function automatic logic adr_ok(input logic [1:0] mode, input logic [7:0] a, input logic [7:0] own);
		logic ok;
		ok = 1'b1;
		if (mode != ADR_NONE) begin
			ok = (a == own);
			if (mode != ADR_OWN) begin
				ok = ok || (a == BCAST_LOW);
			end
			if ((mode != ADR_OWN) && (mode != ADR_BC0)) begin
				ok = ok || (a == BCAST_HIGH);
			end
		end
		return ok;
	endfunction

	// ==========================================================
	// Internal signals offered to the debug pins; unused selector codes read low.
	always_comb begin
		dbg_sig = '0;
		dbg_sig[DBG_PQ_GATE] = pq_gate;
		dbg_sig[DBG_IN_PKT] = (r.st != ST_SEARCH);
		dbg_sig[DBG_BYTE_VALID] = r.dvalid;
		dbg_sig[DBG_RX_BIT] = r.shift[0];
		dbg_sig[DBG_ADR_DROP] = r.drop;
	end

	// ==========================================================
	// Next state of registers, bus answer and receive sequencer.
	always_comb begin
		n = r;
		n.ack = req;
		n.dvalid = 1'b0;
		n.dlast = 1'b0;
		n.drop = 1'b0;
		// The pin values come from the per-pin loop below, so the state copy keeps a single driver.
		n.dbg = dbg_nxt;

		// Bus access: one-cycle registered answer, unmapped offsets read zero and ignore writes.
		if (req) begin
			n.rdat = 8'h00;
			case (idx)
				IDX_SYNC_HIGH: n.rdat = r.sync_high;
				IDX_SYNC_LOW: n.rdat = r.sync_low;
				IDX_PKT_LEN: n.rdat = r.pkt_len;
				IDX_PKT_CTRL1: n.rdat = r.ctrl1 & 8'hE7;
				IDX_PKT_CTRL0: n.rdat = {6'h00, r.len_cfg};
				IDX_DEV_ADDR: n.rdat = r.dev_addr;
				IDX_PIN1_CFG: n.rdat = r.pin1_cfg;
				IDX_PIN0_CFG: n.rdat = r.pin0_cfg & 8'h7F;
				IDX_RX_STATUS: n.rdat = {6'h00, (r.st != ST_SEARCH), pq_gate};
				IDX_RX_COUNT: n.rdat = r.rx_count;
				default: n.rdat = 8'h00;
			endcase
			if (WB_WE_IN && WB_SEL_IN[0]) begin
				case (idx)
					IDX_SYNC_HIGH: n.sync_high = WB_DAT_IN[7:0];
					IDX_SYNC_LOW: n.sync_low = WB_DAT_IN[7:0];
					IDX_PKT_LEN: n.pkt_len = WB_DAT_IN[7:0];
					IDX_PKT_CTRL1: n.ctrl1 = WB_DAT_IN[7:0] & 8'hE7;
					IDX_PKT_CTRL0: n.len_cfg = WB_DAT_IN[1:0];
					IDX_DEV_ADDR: n.dev_addr = WB_DAT_IN[7:0];
					IDX_PIN1_CFG: n.pin1_cfg = WB_DAT_IN[7:0];
					IDX_PIN0_CFG: n.pin0_cfg = WB_DAT_IN[7:0] & 8'h7F;
					default: n.rdat = 8'h00;
				endcase
			end
		end

		// Bits shift in every valid cycle; bytes are assembled most significant bit first.
		if (RX_BIT_VALID_IN) begin
			n.shift = sh_next;
			n.bitcnt = r.bitcnt + 3'h1;
		end

		case (r.st)
			ST_SEARCH: begin
				n.bitcnt = 3'h0;
				if (RX_BIT_VALID_IN && pq_gate && (sh_next == {r.sync_high, r.sync_low})) begin
					if (r.len_cfg != LEN_FIXED) begin
						n.st = ST_LENGTH;
					end else begin
						n.remain = r.pkt_len;
						if (r.pkt_len == 8'h00) begin
							n.st = append_en ? ST_STATUS1 : ST_SEARCH;
							n.rx_count = append_en ? r.rx_count : r.rx_count + 8'h01;
						end else begin
							n.st = (adr_mode != ADR_NONE) ? ST_ADDRESS : ST_PAYLOAD;
						end
					end
				end
			end
			ST_LENGTH: begin
				if (byte_done) begin
					n.hold = rx_byte;
					n.remain = rx_byte;
					if (rx_byte > r.pkt_len) begin
						n.st = ST_SEARCH;
					end else if ((adr_mode != ADR_NONE) && (rx_byte != 8'h00)) begin
						n.st = ST_ADDRESS;
					end else begin
						// Without filtering the length byte is delivered at once.
						n.dout = rx_byte;
						n.dvalid = 1'b1;
						if (rx_byte == 8'h00) begin
							n.dlast = !append_en;
							n.st = append_en ? ST_STATUS1 : ST_SEARCH;
							n.rx_count = append_en ? r.rx_count : r.rx_count + 8'h01;
						end else begin
							n.st = ST_PAYLOAD;
						end
					end
				end
			end
			ST_ADDRESS: begin
				if (byte_done) begin
					n.remain = r.remain - 8'h01;
					if (!adr_ok(adr_mode, rx_byte, r.dev_addr)) begin
						n.drop = 1'b1;
						n.st = ST_SEARCH;
					end else if (r.len_cfg != LEN_FIXED) begin
						// The withheld length byte goes first, the address byte one cycle later.
						n.dout = r.hold;
						n.dvalid = 1'b1;
						n.hold = rx_byte;
						n.st = ST_ADR_EMIT;
					end else begin
						n.dout = rx_byte;
						n.dvalid = 1'b1;
						if (r.remain == 8'h01) begin
							n.dlast = !append_en;
							n.st = append_en ? ST_STATUS1 : ST_SEARCH;
							n.rx_count = append_en ? r.rx_count : r.rx_count + 8'h01;
						end else begin
							n.st = ST_PAYLOAD;
						end
					end
				end
			end
			ST_ADR_EMIT: begin
				n.dout = r.hold;
				n.dvalid = 1'b1;
				if (r.remain == 8'h00) begin
					n.dlast = !append_en;
					n.st = append_en ? ST_STATUS1 : ST_SEARCH;
					n.rx_count = append_en ? r.rx_count : r.rx_count + 8'h01;
				end else begin
					n.st = ST_PAYLOAD;
				end
			end
			ST_PAYLOAD: begin
				if (byte_done) begin
					n.dout = rx_byte;
					n.dvalid = 1'b1;
					n.remain = r.remain - 8'h01;
					if (r.remain == 8'h01) begin
						n.dlast = !append_en;
						n.st = append_en ? ST_STATUS1 : ST_SEARCH;
						n.rx_count = append_en ? r.rx_count : r.rx_count + 8'h01;
					end
				end
			end
			ST_STATUS1: begin
				n.dout = RSSI_IN;
				n.dvalid = 1'b1;
				n.st = ST_STATUS2;
			end
			ST_STATUS2: begin
				n.dout = {CRC_OK_IN, LQI_IN};
				n.dvalid = 1'b1;
				n.dlast = 1'b1;
				n.rx_count = r.rx_count + 8'h01;
				n.st = ST_SEARCH;
			end
			default: n.st = ST_SEARCH;
		endcase
	end

	// ==========================================================
	// Debug pin routing: one selector and one polarity bit per pin.
	genvar gi;
	generate
		for (gi = 0; gi < 2; gi++) begin : g_pin
			logic [7:0] cfg;
			assign cfg = (gi == 0) ? r.pin0_cfg : r.pin1_cfg;
			assign dbg_nxt[gi] = dbg_sig[cfg[PIN_SEL_W-1:0]] ^ cfg[PIN_INV_BIT];
		end
	endgenerate

	// ==========================================================
	// State register; reset loads documented defaults.
	always_ff @(posedge CORE_CLK_IN) begin
		if (!RST_N_IN) begin
			r <= '0;
			r.sync_high <= SYNC_HIGH_RST;
			r.sync_low <= SYNC_LOW_RST;
			r.pkt_len <= PKT_LEN_RST;
			r.ctrl1 <= PKT_CTRL1_RST;
			r.len_cfg <= LEN_CFG_RST;
			r.dev_addr <= DEV_ADDR_RST;
			r.pin1_cfg <= PIN_CFG_RST;
			r.pin0_cfg <= PIN_CFG_RST;
			r.st <= ST_SEARCH;
		end else begin
			r <= n;
		end
	end

	// ==========================================================
	// Outputs, all from flip-flops.
	assign WB_ACK_OUT = r.ack;
	assign WB_DAT_OUT = {24'h000000, r.rdat};
	assign RX_DATA_OUT = r.dout;
	assign RX_VALID_OUT = r.dvalid;
	assign RX_LAST_OUT = r.dlast;
	assign DBG_PIN_OUT = r.dbg;
	assign DBG_DRIVE_STRENGTH_OUT = r.pin1_cfg[PIN_DS_BIT];

endmodule

// file: verif/rpr_packet_rx_checker.sv
// Port-level assertion checker for the radio packet receive block.
module rpr_packet_rx_checker
	import rpr_pkg::*;
#(
	parameter int PQ_CNT_W = 5
) (
	// Clock, reset and bus.
	input wire logic CORE_CLK_IN,
	input wire logic RST_N_IN,
	input wire logic WB_CYC_IN,
	input wire logic WB_STB_IN,
	input wire logic [DAT_W-1:0] WB_DAT_OUT,
	input wire logic WB_ACK_OUT,
	// Receive stream and debug pins.
	input wire logic RX_VALID_OUT,
	input wire logic RX_LAST_OUT,
	input wire logic [1:0] DBG_PIN_OUT
);
	// ==========================================================
	// Everything here lives in the single core clock domain.
	default clocking @(posedge CORE_CLK_IN);
	endclocking
	default disable iff (!RST_N_IN);

	ack_pulse_a: assert property (WB_ACK_OUT |=> !WB_ACK_OUT)
		else $error("ack held over one cycle");
	ack_answer_a: assert property (WB_CYC_IN && WB_STB_IN && !WB_ACK_OUT |=> WB_ACK_OUT)
		else $error("request not answered next cycle");
	ack_cause_a: assert property ($rose(WB_ACK_OUT) |-> $past(WB_CYC_IN && WB_STB_IN))
		else $error("ack without a request");
	read_upper_a: assert property (WB_ACK_OUT |-> WB_DAT_OUT[31:8] == 24'h000000)
		else $error("read data upper lanes not zero");
	last_valid_a: assert property (RX_LAST_OUT |-> RX_VALID_OUT)
		else $error("last flag without valid byte");
	last_end_a: assert property (RX_LAST_OUT |=> (!RX_VALID_OUT)[*2])
		else $error("byte after packet end");
	reset_quiet_a: assert property ($rose(RST_N_IN) |-> !WB_ACK_OUT && !RX_VALID_OUT && DBG_PIN_OUT == 2'h0)
		else $error("outputs busy out of reset");
	pin_default_a: assert property ($rose(RST_N_IN) |=> DBG_PIN_OUT == 2'h3)
		else $error("debug pins not showing open gate");

	// Main scenarios reached.
	pkt_c: cover property (RX_LAST_OUT);
	read_c: cover property (WB_ACK_OUT && WB_DAT_OUT != 32'h00000000);
	inv_c: cover property ($fell(DBG_PIN_OUT[0]));
endmodule

bind rpr_packet_rx rpr_packet_rx_checker #(.PQ_CNT_W(PQ_CNT_W)) chk_u (
	.CORE_CLK_IN(CORE_CLK_IN),
	.RST_N_IN(RST_N_IN),
	.WB_CYC_IN(WB_CYC_IN),
	.WB_STB_IN(WB_STB_IN),
	.WB_DAT_OUT(WB_DAT_OUT),
	.WB_ACK_OUT(WB_ACK_OUT),
	.RX_VALID_OUT(RX_VALID_OUT),
	.RX_LAST_OUT(RX_LAST_OUT),
	.DBG_PIN_OUT(DBG_PIN_OUT)
);

// file: verif/rpr_radio_tx.sv
// Remote transmitter model: serialises bytes onto the demodulated bit stream.
module rpr_radio_tx (
	// Clock.
	input wire logic clk_in,
	// Bit stream and link quality.
	output logic bit_out,
	output logic valid_out,
	output logic [7:0] rssi_out,
	output logic [6:0] lqi_out,
	output logic crc_ok_out
);
	timeunit 1ns;
	timeprecision 100ps;

	// Fixed link quality, so the status bytes are predictable.
	initial begin
		bit_out = 1'h0;
		valid_out = 1'h0;
		rssi_out = 8'hC5;
		lqi_out = 7'h2B;
		crc_ok_out = 1'h1;
	end

	// Most significant bit first, one bit every third cycle to respect spacing.
	task send_byte(input logic [7:0] b);
		for (int i = 7; i >= 0; i--) begin
			@(posedge clk_in);
			bit_out <= b[i];
			valid_out <= 1'h1;
			@(posedge clk_in);
			valid_out <= 1'h0;
			// A stale bit must not look valid, so show its inverse.
			bit_out <= ~b[i];
			@(posedge clk_in);
		end
	endtask
endmodule

// file: verif/rpr_packet_rx_tb.sv
// Self-checking bench for the radio packet receive block.
module rpr_packet_rx_tb
	import rpr_pkg::*;
;
	timeunit 1ns;
	timeprecision 100ps;

	logic clk, rst_n, cyc, stb, we, ack, vld, lst, dstr, rbit, rvld, crc;
	logic [17:0] adr;
	logic [3:0] sel;
	logic [31:0] wdat, rdat, dout;
	logic [7:0] rdata, rssi;
	logic [6:0] lqi;
	logic [1:0] dbg;
	logic [15:0] sync_w;
	logic [7:0] rx_q[$];
	int err_total, n_checks;
	int n_last;
	logic last_tail;

	rpr_packet_rx dut_u (.CORE_CLK_IN(clk), .RST_N_IN(rst_n), .WB_CYC_IN(cyc), .WB_STB_IN(stb),
		.WB_WE_IN(we), .WB_ADR_IN(adr), .WB_SEL_IN(sel), .WB_DAT_IN(wdat), .WB_DAT_OUT(dout),
		.WB_ACK_OUT(ack), .RX_BIT_IN(rbit), .RX_BIT_VALID_IN(rvld), .RSSI_IN(rssi), .LQI_IN(lqi),
		.CRC_OK_IN(crc), .RX_DATA_OUT(rdata), .RX_VALID_OUT(vld), .RX_LAST_OUT(lst),
		.DBG_PIN_OUT(dbg), .DBG_DRIVE_STRENGTH_OUT(dstr));
	rpr_radio_tx tx_u (.clk_in(clk), .bit_out(rbit), .valid_out(rvld), .rssi_out(rssi),
		.lqi_out(lqi), .crc_ok_out(crc));

	// ==========================================================
	// Clock and byte collector.
	initial begin
		clk = 1'h0;
		forever #12.5 clk = ~clk;
	end
	// The collector also notes the end flag, so the packet boundary is judged as well as the bytes.
	always @(posedge clk) begin
		if (vld === 1'h1) begin
			rx_q.push_back(rdata);
			last_tail = lst;
			n_last = n_last + int'(lst === 1'h1);
		end
	end

	// ==========================================================
	// Shared tasks.
	task stop_test;
		$display("checks %0d mismatches %0d", n_checks, err_total);
		if (err_total == 0 && n_checks > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask
	task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		n_checks++;
		if (g !== e) begin
			err_total++;
			$display("wrong value %s expected %h seen %h", nm, e, g);
		end
	endtask
	// One classic cycle; waits for ack rather than assuming a latency.
	task bus(input logic [15:0] idx, input logic w, input logic [7:0] d);
		int t;
		@(posedge clk);
		cyc <= 1'h1;
		stb <= 1'h1;
		we <= w;
		adr <= {idx, 2'h0};
		wdat <= {24'h000000, d};
		t = 0;
		do begin
			@(posedge clk);
			t++;
		end while (ack !== 1'h1 && t < 50);
		rdat = dout;
		cyc <= 1'h0;
		stb <= 1'h0;
		chk("ack seen", 1, t < 50);
	endtask
	task wr(input logic [15:0] idx, input logic [7:0] d);
		bus(idx, 1'h1, d);
	endtask
	task rchk(input string nm, input logic [15:0] idx, input logic [7:0] e);
		bus(idx, 1'h0, 8'h00);
		chk(nm, {24'h000000, e}, rdat);
	endtask
	// Zero preamble, sync word, then the first n of three bytes.
	task pkt(input logic [7:0] b0, b1, b2, input int n, en, input logic [7:0] lastb);
		rx_q.delete();
		n_last = 0;
		tx_u.send_byte(8'h00);
		tx_u.send_byte(sync_w[15:8]);
		tx_u.send_byte(sync_w[7:0]);
		if (n > 0) tx_u.send_byte(b0);
		if (n > 1) tx_u.send_byte(b1);
		if (n > 2) tx_u.send_byte(b2);
		repeat (8) @(posedge clk);
		chk("byte count", en, rx_q.size());
		chk("last flags", (en > 0) ? 1 : 0, n_last);
		if (en > 0) begin
			chk("last on end", 1, last_tail);
			chk("first byte", b0, rx_q[0]);
			chk("last byte", lastb, rx_q[$]);
		end
	endtask

	// ==========================================================
	// Scenarios.
	task t_reset;
		rchk("sync hi", IDX_SYNC_HIGH, 8'hD3);
		rchk("sync lo", IDX_SYNC_LOW, 8'h91);
		rchk("length", IDX_PKT_LEN, 8'hFF);
		rchk("ctrl one", IDX_PKT_CTRL1, 8'h04);
		rchk("len cfg", IDX_PKT_CTRL0, 8'h01);
		rchk("address", IDX_DEV_ADDR, 8'h00);
		rchk("pin0 cfg", IDX_PIN0_CFG, 8'h00);
		rchk("pin1 cfg", IDX_PIN1_CFG, 8'h00);
		rchk("rx status", IDX_RX_STATUS, 8'h01);
		chk("dbg pins", 2'h3, dbg);
		$display("test reset done");
	endtask
	task t_bus;
		wr(IDX_PKT_CTRL1, 8'hFF);
		rchk("ctrl one mask", IDX_PKT_CTRL1, 8'hE7);
		wr(IDX_PKT_CTRL1, 8'h04);
		wr(IDX_PIN0_CFG, 8'hFF);
		rchk("pin0 mask", IDX_PIN0_CFG, 8'h7F);
		wr(16'hDF20, 8'h5A);
		rchk("unmapped", 16'hDF20, 8'h00);
		wr(IDX_SYNC_LOW, 8'h3C);
		rchk("sync lo rw", IDX_SYNC_LOW, 8'h3C);
		wr(IDX_SYNC_LOW, 8'h91);
		$display("test bus done");
	endtask
	task t_dbg;
		wr(IDX_PIN0_CFG, 8'h40);
		wr(IDX_PIN1_CFG, 8'h80);
		repeat (2) @(posedge clk);
		chk("dbg inverted", 2'h2, dbg);
		chk("drive str", 1'h1, dstr);
		wr(IDX_PIN0_CFG, 8'h00);
		wr(IDX_PIN1_CFG, 8'h41);
		repeat (2) @(posedge clk);
		chk("dbg select", 2'h3, dbg);
		chk("drive str off", 1'h0, dstr);
		$display("test debug done");
	endtask
	task t_filter;
		logic [7:0] a;
		int acc;
		wr(IDX_DEV_ADDR, 8'h5A);
		for (int m = 0; m < 4; m++) begin
			for (int i = 0; i < 4; i++) begin
				a = (i == 0) ? 8'h5A : (i == 1) ? 8'h00 : (i == 2) ? 8'hFF : 8'h33;
				wr(IDX_PKT_CTRL1, {6'h01, m[1:0]});
				acc = (m == 0 || a == 8'h5A || (m >= 2 && a == 8'h00) || (m == 3 && a == 8'hFF));
				pkt(8'h02, a, 8'h3C, 3, acc ? 5 : 0, 8'hAB);
			end
		end
		$display("test filter done");
	endtask
	task t_len;
		wr(IDX_PKT_CTRL1, 8'h04);
		wr(IDX_PKT_LEN, 8'h01);
		pkt(8'h02, 8'h11, 8'h22, 3, 0, 8'h00);
		pkt(8'h01, 8'h11, 8'h00, 2, 4, 8'hAB);
		wr(IDX_PKT_CTRL0, 8'h00);
		wr(IDX_PKT_LEN, 8'h02);
		pkt(8'h77, 8'h66, 8'h00, 2, 4, 8'hAB);
		wr(IDX_PKT_CTRL1, 8'h00);
		pkt(8'h77, 8'h66, 8'h00, 2, 2, 8'h66);
		// Code 11 is taken as variable length, so the next test also covers it.
		wr(IDX_PKT_CTRL0, 8'h03);
		$display("test length done");
	endtask
	// Counter reaches 5 before the last sync bit: passes threshold 4, fails 8.
	task t_pqt;
		wr(IDX_SYNC_HIGH, 8'h55);
		wr(IDX_SYNC_LOW, 8'h53);
		sync_w = 16'h5553;
		wr(IDX_PKT_CTRL1, 8'h24);
		pkt(8'h01, 8'h11, 8'h00, 2, 4, 8'hAB);
		wr(IDX_PKT_CTRL1, 8'h44);
		pkt(8'h01, 8'h11, 8'h00, 2, 0, 8'h00);
		// Ten packets pass the filter test, three the length test and one here.
		rchk("packet count", IDX_RX_COUNT, 8'h0E);
		$display("test quality done");
	endtask

	// ==========================================================
	// Main sequence and watchdog.
	initial begin
		rst_n = 1'h0;
		cyc = 1'h0;
		stb = 1'h0;
		we = 1'h0;
		adr = 18'h00000;
		sel = 4'hF;
		wdat = 32'h00000000;
		sync_w = 16'hD391;
		repeat (2) @(posedge clk);
		rst_n <= 1'h1;
		@(posedge clk);
		t_reset();
		t_bus();
		t_dbg();
		t_filter();
		t_len();
		t_pqt();
		stop_test();
	end
	initial begin
		#(25 * 20000);
		err_total++;
		stop_test();
	end
endmodule
